// ---- common/sxt_pkg.sv ----
// Purpose: Shared types and constants for the subtract/swap/xor/table unit
// Assumes: 8-bit data path, 6-bit register address, 12-bit program counter
// Notes:   Opcode encodings are local to this unit, not instruction bits
`default_nettype none
package sxt_pkg;

    localparam int unsigned DATA_W   = 8;
    localparam int unsigned ADDR_W   = 6;
    localparam int unsigned PC_W     = 12;
    localparam int unsigned PAGE_W   = 2;
    localparam int unsigned NIB_W    = 4;

    // Program counter field positions
    localparam int unsigned PC_LOW_MSB  = 7;
    localparam int unsigned PC_MID_MSB  = 9;
    localparam int unsigned PC_MID_LSB  = 8;
    localparam int unsigned PC_PAGE_MSB = 11;
    localparam int unsigned PC_PAGE_LSB = 10;

    // Reset values
    localparam logic [7:0]  ACC_RESET   = 8'h00;
    localparam logic        FLAG_RESET  = 1'b0;
    localparam logic [11:0] PC_RESET    = 12'h000;
    localparam logic [5:0]  ADDR_RESET  = 6'h00;

    // Destination select: 0 selects the accumulator, 1 the register
    localparam logic DEST_ACC = 1'b0;
    localparam logic DEST_REG = 1'b1;

    // Cycles of fetch flush after a table jump
    localparam int unsigned FLUSH_CYCLES = 1;

    typedef enum logic [2:0] {
        SXT_OP_REG_MINUS_ACCUM = 3'h0,
        SXT_OP_IMM_MINUS_ACCUM = 3'h1,
        SXT_OP_NIBBLE_EXCHANGE = 3'h2,
        SXT_OP_TABLE_JUMP      = 3'h3,
        SXT_OP_REG_XOR         = 3'h4,
        SXT_OP_IMM_XOR         = 3'h5
    } sxt_opcode_t;

    typedef struct packed {
        sxt_opcode_t       code;
        logic              dest;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] imm;
    } sxt_op_t;

    typedef struct packed {
        logic c;
        logic half_carry_flag;
        logic z;
    } sxt_flags_t;

endpackage
`default_nettype wire

// ---- hdl/sxt_alu.sv ----
// Purpose: Combinational arithmetic for the six operations
// Assumes: Register operand is already read for the addressed register
// Notes:   Carry means no borrow for both subtract forms
`timescale 1ns/1ps
`default_nettype none
module sxt_alu #(
    parameter int unsigned DW = 8
) (
    input  wire sxt_pkg::sxt_op_t    op,
    input  wire logic [DW-1:0]       acc,
    input  wire logic [DW-1:0]       reg_val,
    input  wire logic [DW-1:0]       pc_low,
    output logic      [DW-1:0]       result,
    output sxt_pkg::sxt_flags_t      flags,
    output sxt_pkg::sxt_flags_t      upd
);
    logic [DW:0]   sum;
    logic [4:0]    low_sum;
    logic [DW-1:0] lhs;
    logic [DW-1:0] rhs;
    logic          cin;

    always_comb begin
        lhs = reg_val;
        rhs = ~acc;
        cin = 1'b1;
        upd = '0;
        case (op.code)
            sxt_pkg::SXT_OP_REG_MINUS_ACCUM: begin
                upd = '{c: 1'b1, half_carry_flag: 1'b1, z: 1'b1};
            end
            sxt_pkg::SXT_OP_IMM_MINUS_ACCUM: begin
                lhs = op.imm;
                upd = '{c: 1'b1, half_carry_flag: 1'b1, z: 1'b1};
            end
            sxt_pkg::SXT_OP_TABLE_JUMP: begin
                lhs = pc_low;
                rhs = acc;
                cin = 1'b0;
                upd = '{c: 1'b1, half_carry_flag: 1'b1, z: 1'b1};
            end
            sxt_pkg::SXT_OP_REG_XOR, sxt_pkg::SXT_OP_IMM_XOR: begin
                upd.z = 1'b1;
            end
            default: begin
                upd = '0;
            end
        endcase
        sum     = {1'b0, lhs} + {1'b0, rhs} + {{DW{1'b0}}, cin};
        low_sum = {1'b0, lhs[3:0]} + {1'b0, rhs[3:0]} + {4'h0, cin};
        case (op.code)
            sxt_pkg::SXT_OP_NIBBLE_EXCHANGE: result = {reg_val[3:0], reg_val[DW-1:4]};
            sxt_pkg::SXT_OP_REG_XOR:         result = acc ^ reg_val;
            sxt_pkg::SXT_OP_IMM_XOR:         result = acc ^ op.imm;
            default:                         result = sum[DW-1:0];
        endcase
        flags.z               = (result == '0);
        flags.c               = sum[DW];
        flags.half_carry_flag = low_sum[4];
    end
endmodule
`default_nettype wire

// ---- hdl/sxt_exec_unit.sv ----
// Purpose: Executes subtract, nibble swap, table jump and xor operations
// Assumes: Register file read data is valid for OP_ADDR in the issue cycle
// Notes:   Holds accumulator and flags; register writes leave as a pulse
//
// What this block does
// - Register minus accumulator, address 0..63, sets carry, half carry, zero.
// - Register forms: destination bit 0 writes accumulator, 1 writes register.
// - Immediate minus accumulator into accumulator, sets carry, half carry, zero.
// - Nibble exchange swaps register halves; no flag changes.
// - Table jump adds accumulator to counter low byte; page bits fill top.
// - Table jump takes no operand; pairs with return-with-literal entries.
// - Register xor with accumulator to chosen destination; only zero changes.
// - Immediate xor with accumulator into accumulator; only zero changes.
`timescale 1ns/1ps
`default_nettype none
module sxt_exec_unit #(
    parameter int unsigned DW = 8
) (
    input  wire logic                    SYS_CLK,
    input  wire logic                    RST_N,
    input  wire logic                    OP_VALID,
    output logic                         OP_READY,
    input  wire logic [2:0]              OP_CODE,
    input  wire logic                    OP_DEST,
    input  wire logic [5:0]              OP_ADDR,
    input  wire logic [DW-1:0]           OP_IMM,
    input  wire logic [DW-1:0]           REG_RDATA,
    input  wire logic [11:0]             PC_IN,
    input  wire logic [1:0]              PAGE_SELECT_BITS,
    output logic [DW-1:0]                ACC_OUT,
    output logic                         CARRY_OUT,
    output logic                         HALF_CARRY_FLAG_OUT,
    output logic                         ZERO_OUT,
    output logic                         REG_WE,
    output logic [5:0]                   REG_WADDR,
    output logic [DW-1:0]                REG_WDATA,
    output logic                         PC_LOAD,
    output logic [11:0]                  PC_NEXT,
    output logic                         FETCH_FLUSH,
    output logic                         OP_DONE
);
    if (DW != sxt_pkg::DATA_W) begin : g_width_check
        $error("sxt_exec_unit supports only an 8-bit data path");
    end

    typedef enum logic [1:0] {
        SXT_ST_RUN   = 2'b01,
        SXT_ST_FLUSH = 2'b10
    } sxt_state_t;

    // Register destination only for the register-operand forms
    function automatic logic writes_reg(input sxt_pkg::sxt_op_t o);
        case (o.code)
            sxt_pkg::SXT_OP_REG_MINUS_ACCUM,
            sxt_pkg::SXT_OP_NIBBLE_EXCHANGE,
            sxt_pkg::SXT_OP_REG_XOR: writes_reg = (o.dest == sxt_pkg::DEST_REG);
            default:                 writes_reg = 1'b0;
        endcase
    endfunction

    function automatic logic known_op(input logic [2:0] c);
        case (c)
            sxt_pkg::SXT_OP_REG_MINUS_ACCUM,
            sxt_pkg::SXT_OP_IMM_MINUS_ACCUM,
            sxt_pkg::SXT_OP_NIBBLE_EXCHANGE,
            sxt_pkg::SXT_OP_TABLE_JUMP,
            sxt_pkg::SXT_OP_REG_XOR,
            sxt_pkg::SXT_OP_IMM_XOR: known_op = 1'b1;
            default:                 known_op = 1'b0;
        endcase
    endfunction

    sxt_pkg::sxt_op_t    op;
    sxt_pkg::sxt_flags_t alu_flags;
    sxt_pkg::sxt_flags_t alu_upd;
    logic [DW-1:0]       alu_result;
    logic                take;
    logic                is_table_jump;

    sxt_state_t          state_q;
    sxt_state_t          state_d;
    logic [DW-1:0]       acc_q;
    logic [DW-1:0]       acc_d;
    sxt_pkg::sxt_flags_t flags_q;
    sxt_pkg::sxt_flags_t flags_d;
    logic                reg_we_q;
    logic                reg_we_d;
    logic [5:0]          reg_waddr_q;
    logic [5:0]          reg_waddr_d;
    logic [DW-1:0]       reg_wdata_q;
    logic [DW-1:0]       reg_wdata_d;
    logic                pc_load_q;
    logic                pc_load_d;
    logic [11:0]         pc_next_q;
    logic [11:0]         pc_next_d;
    logic                done_q;
    logic                done_d;

    always_comb begin
        op.code = sxt_pkg::sxt_opcode_t'(OP_CODE);
        op.dest = OP_DEST;
        op.addr = OP_ADDR;
        op.imm  = OP_IMM;
    end

    sxt_alu #(
        .DW (DW)
    ) u_alu (
        .op      (op),
        .acc     (acc_q),
        .reg_val (REG_RDATA),
        .pc_low  (PC_IN[sxt_pkg::PC_LOW_MSB:0]),
        .result  (alu_result),
        .flags   (alu_flags),
        .upd     (alu_upd)
    );

    assign OP_READY = (state_q == SXT_ST_RUN);
    // Unknown codes are accepted and dropped so the core never hangs
    assign take     = OP_VALID && OP_READY && known_op(OP_CODE);
    assign is_table_jump = (op.code == sxt_pkg::SXT_OP_TABLE_JUMP);

    always_comb begin
        state_d     = state_q;
        acc_d       = acc_q;
        flags_d     = flags_q;
        reg_we_d    = 1'b0;
        reg_waddr_d = reg_waddr_q;
        reg_wdata_d = reg_wdata_q;
        pc_load_d   = 1'b0;
        pc_next_d   = pc_next_q;
        done_d      = 1'b0;
        case (state_q)
            SXT_ST_RUN: begin
                if (take) begin
                    done_d = 1'b1;
                    if (writes_reg(op)) begin
                        reg_we_d    = 1'b1;
                        reg_waddr_d = op.addr;
                        reg_wdata_d = alu_result;
                    end else if (!is_table_jump) begin
                        acc_d = alu_result;
                    end
                    if (alu_upd.c) begin
                        flags_d.c = alu_flags.c;
                    end
                    if (alu_upd.half_carry_flag) begin
                        flags_d.half_carry_flag = alu_flags.half_carry_flag;
                    end
                    if (alu_upd.z) begin
                        flags_d.z = alu_flags.z;
                    end
                    if (is_table_jump) begin
                        pc_load_d = 1'b1;
                        pc_next_d = {PAGE_SELECT_BITS,
                                     PC_IN[sxt_pkg::PC_MID_MSB:
                                           sxt_pkg::PC_MID_LSB],
                                     alu_result};
                        state_d   = SXT_ST_FLUSH;
                    end
                end
            end
            SXT_ST_FLUSH: begin
                state_d = SXT_ST_RUN;
            end
            default: begin
                state_d = SXT_ST_RUN;
            end
        endcase
    end

    always_ff @(posedge SYS_CLK or negedge RST_N) begin
        if (!RST_N) begin
            state_q     <= SXT_ST_RUN;
            acc_q       <= sxt_pkg::ACC_RESET;
            flags_q     <= '{c: sxt_pkg::FLAG_RESET,
                             half_carry_flag: sxt_pkg::FLAG_RESET,
                             z: sxt_pkg::FLAG_RESET};
            reg_we_q    <= 1'b0;
            reg_waddr_q <= sxt_pkg::ADDR_RESET;
            reg_wdata_q <= sxt_pkg::ACC_RESET;
            pc_load_q   <= 1'b0;
            pc_next_q   <= sxt_pkg::PC_RESET;
            done_q      <= 1'b0;
        end else begin
            state_q     <= state_d;
            acc_q       <= acc_d;
            flags_q     <= flags_d;
            reg_we_q    <= reg_we_d;
            reg_waddr_q <= reg_waddr_d;
            reg_wdata_q <= reg_wdata_d;
            pc_load_q   <= pc_load_d;
            pc_next_q   <= pc_next_d;
            done_q      <= done_d;
        end
    end

    assign ACC_OUT             = acc_q;
    assign CARRY_OUT           = flags_q.c;
    assign HALF_CARRY_FLAG_OUT = flags_q.half_carry_flag;
    assign ZERO_OUT            = flags_q.z;
    assign REG_WE              = reg_we_q;
    assign REG_WADDR           = reg_waddr_q;
    assign REG_WDATA           = reg_wdata_q;
    assign PC_LOAD             = pc_load_q;
    assign PC_NEXT             = pc_next_q;
    // Flush marks the cycle in which the redirected fetch is discarded
    assign FETCH_FLUSH         = (state_q == SXT_ST_FLUSH);
    assign OP_DONE             = done_q;
endmodule
`default_nettype wire

// ---- tb/sxt_exec_monitor.sv ----
// Purpose: Port-level checker for the execution unit
// Assumes: One clock domain, reset active low
// Notes:   Codes 6 and 7 count as not taken, so they raise no done
`timescale 1ns/1ps
`default_nettype none
module sxt_exec_monitor #(
    parameter int unsigned DW = 8
) (
    input wire logic          SYS_CLK,
    input wire logic          RST_N,
    input wire logic          OP_VALID,
    input wire logic          OP_READY,
    input wire logic [2:0]    OP_CODE,
    input wire logic          OP_DEST,
    input wire logic [5:0]    OP_ADDR,
    input wire logic [DW-1:0] OP_IMM,
    input wire logic [DW-1:0] REG_RDATA,
    input wire logic [11:0]   PC_IN,
    input wire logic [1:0]    PAGE_SELECT_BITS,
    input wire logic [DW-1:0] ACC_OUT,
    input wire logic          CARRY_OUT,
    input wire logic          HALF_CARRY_FLAG_OUT,
    input wire logic          ZERO_OUT,
    input wire logic          REG_WE,
    input wire logic [5:0]    REG_WADDR,
    input wire logic [DW-1:0] REG_WDATA,
    input wire logic          PC_LOAD,
    input wire logic [11:0]   PC_NEXT,
    input wire logic          FETCH_FLUSH,
    input wire logic          OP_DONE
);
    wire logic take;
    assign take = OP_VALID && OP_READY && (OP_CODE <= 3'h5);
    default clocking cb @(posedge SYS_CLK); endclocking
    default disable iff (!RST_N);
    a_done_next: assert property (
        take |=> OP_DONE) else $error("done missing after op");
    a_no_stray_done: assert property (
        !take |=> !OP_DONE) else $error("done without op");
    a_sub_reg_write: assert property (
        take && OP_CODE == 3'h0 && OP_DEST |=> REG_WE
        && REG_WDATA == $past(REG_RDATA) - $past(ACC_OUT)
        && REG_WADDR == $past(OP_ADDR) && $stable(ACC_OUT))
        else $error("register subtract wrong");
    a_imm_sub_acc: assert property (
        take && OP_CODE == 3'h1 |=> ACC_OUT == $past(OP_IMM) - $past(ACC_OUT)
        && CARRY_OUT == ($past(OP_IMM) >= $past(ACC_OUT))
        && ZERO_OUT == (ACC_OUT == '0)) else $error("immediate subtract wrong");
    a_swap_flags_kept: assert property (
        take && OP_CODE == 3'h2 |=>
        $stable({CARRY_OUT, HALF_CARRY_FLAG_OUT, ZERO_OUT}))
        else $error("swap changed flags");
    a_table_pc_next: assert property (
        take && OP_CODE == 3'h3 |=> PC_LOAD && FETCH_FLUSH && !OP_READY
        && PC_NEXT[7:0] == $past(PC_IN[7:0]) + $past(ACC_OUT)
        && PC_NEXT[11:8] == {$past(PAGE_SELECT_BITS), $past(PC_IN[9:8])}
        ##1 OP_READY) else $error("table jump wrong");
    a_reg_xor_zero: assert property (
        take && OP_CODE == 3'h4 |=> $stable(CARRY_OUT)
        && ZERO_OUT == (($past(ACC_OUT) ^ $past(REG_RDATA)) == '0))
        else $error("register xor wrong");
    a_imm_xor_acc: assert property (
        take && OP_CODE == 3'h5 |=>
        ACC_OUT == ($past(OP_IMM) ^ $past(ACC_OUT))
        && $stable({CARRY_OUT, HALF_CARRY_FLAG_OUT}) && !REG_WE
        && ZERO_OUT == (ACC_OUT == '0)) else $error("immediate xor wrong");
    a_write_needs_dest: assert property (
        REG_WE |-> $past(OP_DEST)) else $error("register write on acc dest");
    c_table: cover property (take && OP_CODE == 3'h3);
    c_reg_write: cover property (REG_WE);
    c_zero: cover property (OP_DONE && ZERO_OUT);
endmodule
bind sxt_exec_unit sxt_exec_monitor #(.DW(DW)) u_mon (
    .SYS_CLK(SYS_CLK), .RST_N(RST_N), .OP_VALID(OP_VALID),
    .OP_READY(OP_READY), .OP_CODE(OP_CODE), .OP_DEST(OP_DEST),
    .OP_ADDR(OP_ADDR), .OP_IMM(OP_IMM), .REG_RDATA(REG_RDATA),
    .PC_IN(PC_IN), .PAGE_SELECT_BITS(PAGE_SELECT_BITS), .ACC_OUT(ACC_OUT),
    .CARRY_OUT(CARRY_OUT), .HALF_CARRY_FLAG_OUT(HALF_CARRY_FLAG_OUT),
    .ZERO_OUT(ZERO_OUT), .REG_WE(REG_WE), .REG_WADDR(REG_WADDR),
    .REG_WDATA(REG_WDATA), .PC_LOAD(PC_LOAD), .PC_NEXT(PC_NEXT),
    .FETCH_FLUSH(FETCH_FLUSH), .OP_DONE(OP_DONE));
`default_nettype wire

// ---- tb/tb_sxt_exec_unit.sv ----
// Purpose: Self-checking bench for the execution unit
// Assumes: One operand byte feeds register data, immediate, address and PC
// Notes:   Ops are spaced by one idle cycle; back to back is left to checker
`timescale 1ns/1ps
`default_nettype none
module tb_sxt_exec_unit;
    logic        clk = 0, rst_n = 0, vld = 0, dst = 0;
    logic [2:0]  code = 0;
    logic [7:0]  opnd = 0, ea = 0, acc_o, wdata;
    logic        rdy, c_o, h_o, z_o, we, ld, fl, done, ec = 0, eh = 0, ez = 0;
    logic [5:0]  waddr;
    logic [11:0] pcn;
    int          bad_count = 0, check_count = 0;
    // Entry: code nibble, dest nibble, operand byte
    logic [15:0] ops [13] = '{16'h50a5, 16'h00a5, 16'h1010, 16'h010f,
        16'h1105, 16'h203c, 16'h21ff, 16'h6033, 16'h41c3, 16'h4001,
        16'h30fe, 16'h51c2, 16'h3000};
    always #20 clk = ~clk;
    sxt_exec_unit #(.DW(8)) dut (.SYS_CLK(clk), .RST_N(rst_n),
        .OP_VALID(vld), .OP_READY(rdy), .OP_CODE(code), .OP_DEST(dst),
        .OP_ADDR(opnd[5:0]), .OP_IMM(opnd), .REG_RDATA(opnd),
        .PC_IN({opnd[3:0], opnd}), .PAGE_SELECT_BITS(opnd[7:6]),
        .ACC_OUT(acc_o), .CARRY_OUT(c_o), .HALF_CARRY_FLAG_OUT(h_o),
        .ZERO_OUT(z_o), .REG_WE(we), .REG_WADDR(waddr), .REG_WDATA(wdata),
        .PC_LOAD(ld), .PC_NEXT(pcn), .FETCH_FLUSH(fl), .OP_DONE(done));
    task automatic chk(input string nm, input logic [15:0] seen,
                       input logic [15:0] exp);
        check_count++;
        if (seen !== exp) begin
            bad_count++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic stop_test;
        $display("Checks %0d mismatches %0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    task automatic run(input logic [15:0] e);
        logic [8:0] s;
        logic [7:0] res;
        logic       wr;
        @(posedge clk);
        code <= e[14:12];
        dst <= e[8];
        opnd <= e[7:0];
        vld <= 1'b1;
        repeat (4) begin
            @(negedge clk);
            if (rdy === 1'b1) break;
        end
        @(posedge clk);
        vld <= 1'b0;
        @(negedge clk);
        res = ea;
        wr = e[8] & ~e[12];
        case (e[14:12])
            3'h0, 3'h1: begin
                s = {1'b0, e[7:0]} - {1'b0, ea};
                res = s[7:0];
                ec = ~s[8];
                eh = e[3:0] >= ea[3:0];
                ez = res == 8'h00;
            end
            3'h2: res = {e[3:0], e[7:4]};
            3'h3: begin
                s = {1'b0, e[7:0]} + {1'b0, ea};
                ec = s[8];
                eh = ({1'b0, e[3:0]} + ea[3:0]) > 5'h0f;
                ez = s[7:0] == 8'h00;
                chk("pc_next", pcn, {e[7:6], e[1:0], s[7:0]});
                chk("ready_flush_load", {rdy, fl, ld}, 3'h3);
            end
            3'h4, 3'h5: begin
                res = ea ^ e[7:0];
                ez = res == 8'h00;
            end
            default: ;
        endcase
        if (e[14:12] < 3'h6 && e[14:12] != 3'h3 && !wr) ea = res;
        chk("acc", acc_o, ea);
        chk("flags", {c_o, h_o, z_o}, {ec, eh, ez});
        chk("done", done, e[14:12] < 3'h6);
        chk("reg_we", we, wr);
        if (wr) chk("reg_write", {waddr, wdata}, {e[5:0], res});
        $display("Test op %h finished", e);
    endtask
    initial begin
        repeat (3000) @(posedge clk);
        bad_count++;
        stop_test;
    end
    initial begin
        repeat (4) @(posedge clk);
        rst_n <= 1'b1;
        foreach (ops[i]) run(ops[i]);
        // Nonzero accumulator, carry without half carry, before reset
        run(16'h5015);
        run(16'h1033);
        // Reset in mid-run must restart from a clear accumulator
        @(posedge clk);
        rst_n <= 1'b0;
        {ea, ec, eh, ez} = '0;
        @(negedge clk);
        chk("rst_out", {acc_o, c_o, h_o, z_o, we, ld, fl}, 14'h0);
        chk("rst_hs", {done, rdy}, 2'h1);
        @(posedge clk);
        rst_n <= 1'b1;
        run(16'h1000);
        stop_test;
    end
endmodule
`default_nettype wire
